// [icc_pkg.sv]
// Constants and carrier types shared by the image coder control register bank.
package icc_pkg;

  // Host register addresses.
  localparam logic [3:0] ADDR_SYS   = 4'h0;
  localparam logic [3:0] ADDR_PARAM = 4'h1;
  localparam logic [3:0] ADDR_CMD   = 4'h2;
  localparam logic [3:0] ADDR_IEN   = 4'h3;

  // Field positions in system_config.
  localparam int SYS_HR  = 0;
  localparam int SYS_CB  = 1;
  localparam int SYS_DS  = 3;
  localparam int SYS_BS  = 4;
  localparam int SYS_BX  = 5;
  localparam int SYS_PI  = 6;
  localparam int SYS_PB  = 7;

  // Field positions in template_params.
  localparam int PAR_ATLO = 0;
  localparam int PAR_TM   = 5;
  localparam int PAR_ATHI = 6;

  // Field positions in command_ctrl; status_flags reads back in its own layout, with the pause select at bit 5.
  localparam int CMD_IC = 0;
  localparam int CMD_JC = 1;
  localparam int CMD_RC = 2;
  localparam int CMD_JP = 3;

  // Field positions in irq_enable.
  localparam int IEN_JE = 0;
  localparam int IEN_DE = 1;
  localparam int IEN_ME = 2;
  localparam int IEN_SE = 3;
  localparam int IEN_MP = 7;
  localparam logic [7:0] IEN_MASK = 8'h8f;

  // Code bus width encodings.
  localparam logic [1:0] CB_8  = 2'h0;
  localparam logic [1:0] CB_16 = 2'h1;
  localparam logic [1:0] CB_32 = 2'h2;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Configuration handed to the coding datapath.
  typedef struct packed {
    logic [1:0] code_bus_width;
    logic       code_bit_order;
    logic       code_byte_order;
    logic       image_if_select;
    logic       image_bus_width;
    logic       image_bit_swap;
    logic [6:0] adaptive_pixel_pos;
    logic       template_select;
    logic       pause_select;
    logic       marker_pause;
  } icc_cfg_s;

  // Events and levels reported by the coding datapath.
  typedef struct packed {
    logic init_done;
    logic lines_done;
    logic code_all_read;
    logic image_all_read;
    logic marker_seen;
    logic ff_overflow;
    logic code_xfer_request;
    logic coding_active;
    logic code_byte;
  } icc_evt_s;

  // Commands issued to the coding datapath.
  typedef struct packed {
    logic       core_reset;
    logic       ram_init_run;
    logic       process_run;
    logic       process_start;
    logic       process_stop;
    logic       context_xfer_run;
    logic [1:0] pad_bytes;
  } icc_ctl_s;

endpackage

// [icc_sync.sv]
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps
module icc_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         mclk,
  input  wire logic         resetn,
  // Asynchronous input and settled output.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out,
  // Value seen before reset release.
  input  wire logic [W-1:0] idle_value
);
  import icc_pkg::*;

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] q;
  } icc_sync_s;

  icc_sync_s st;
  icc_sync_s next_st;
  logic      started;

  // The first stage only feeds the second, so metastability never reaches logic.
  always_comb begin
    next_st     = st;
    next_st.ff1 = async_in;
    next_st.ff2 = st.ff1;
    next_st.ff3 = st.ff2;
    for (int i = 0; i < W; i++) begin
      if (st.ff2[i] == st.ff3[i]) begin
        next_st.q[i] = st.ff3[i];
      end
    end
    // Reset zeros in the later stages would read as active strobes, so they are primed with the idle level.
    if (!started) begin
      next_st.ff2 = idle_value;
      next_st.ff3 = idle_value;
      next_st.q   = idle_value;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st      <= '0;
      started <= 1'b0;
    end else begin
      st      <= next_st;
      started <= 1'b1;
    end
  end

  // Until the pipe has filled once, report the idle level rather than zeros.
  assign sync_out = started ? st.q : idle_value;

endmodule

// [icc_bus_order.sv]
// Lane and bit ordering of the code data bus and the parallel image bus.
`timescale 1ns/100ps
module icc_bus_order (
  // Clock and reset.
  input  wire logic     mclk,
  input  wire logic     resetn,
  // Ordering selection.
  input  icc_pkg::icc_cfg_s cfg,
  // Time-ordered words, bit k is the k-th in time.
  input  wire logic [31:0] code_word,
  input  wire logic [31:0] pix_word,
  // Bus-ordered words.
  output logic      [31:0] code_bus,
  output logic      [31:0] image_bus
);
  import icc_pkg::*;

  typedef struct packed {
    logic [31:0] code_bus;
    logic [31:0] image_bus;
  } icc_order_s;

  icc_order_s st;
  icc_order_s next_st;

  function automatic logic [2:0] lanes(input logic [1:0] cb);
    unique case (cb)
      CB_16:   lanes = 3'h2;
      CB_32:   lanes = 3'h4;
      default: lanes = 3'h1;
    endcase
  endfunction

  always_comb begin
    logic [2:0] n;
    logic [1:0] bi;
    n       = lanes(cfg.code_bus_width);
    bi      = 2'h0;
    next_st = '0;
    for (int i = 0; i < 4; i++) begin
      // Byte swap only reverses lanes on wide buses.
      if (cfg.code_byte_order && n != 3'h1) begin
        bi = 2'(int'(n) - 1 - i);
      end else begin
        bi = 2'(i);
      end
      if (i < int'(n)) begin
        for (int j = 0; j < 8; j++) begin
          if (cfg.code_bit_order) begin
            next_st.code_bus[8*i+j] = code_word[8*bi+j];
          end else begin
            next_st.code_bus[8*i+7-j] = code_word[8*bi+j];
          end
        end
      end
    end
    if (cfg.image_if_select) begin
      for (int k = 0; k < 32; k++) begin
        if (!cfg.image_bus_width) begin
          if (cfg.image_bit_swap) begin
            next_st.image_bus[k] = pix_word[k];
          end else begin
            next_st.image_bus[31-k] = pix_word[k];
          end
        end else if (k < 16) begin
          if (cfg.image_bit_swap) begin
            next_st.image_bus[k] = pix_word[k];
          end else begin
            next_st.image_bus[15-k] = pix_word[k];
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign code_bus  = st.code_bus;
  assign image_bus = st.image_bus;

endmodule

// [icc_regs.sv]
// Host control and status register bank of the binary image coder.
`timescale 1ns/100ps
module icc_regs (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Host bus pins.
  input  wire logic        host_cs_n,
  input  wire logic        host_rd_n,
  input  wire logic        host_wr_n,
  input  wire logic [3:0]  host_addr,
  input  wire logic [7:0]  host_data_in,
  output logic      [7:0]  host_data_out,
  output logic             host_data_oe,
  // Datapath side.
  input  icc_pkg::icc_evt_s evt,
  input  wire logic [31:0] code_word,
  input  wire logic [31:0] pix_word,
  output icc_pkg::icc_cfg_s cfg,
  output icc_pkg::icc_ctl_s ctl,
  output logic      [31:0] code_bus,
  output logic      [31:0] image_bus,
  // Interrupt and request pins.
  output logic             irq_out,
  output logic             code_xfer_request
);
  import icc_pkg::*;

  typedef struct packed {
    logic       wr_q;
    logic [7:0] system_config;
    logic [7:0] template_params;
    logic       ram_init_cmd;
    logic       process_cmd;
    logic       context_xfer_cmd;
    logic       pause_select;
    logic       completion_flag;
    logic       marker_seen_flag;
    logic       ff_overflow_flag;
    logic       pause_hit;
    logic [7:0] irq_enable;
    logic       irq;
    logic       xfer_req;
    logic       start_p;
    logic       stop_p;
    logic [1:0] byte_cnt;
    logic [7:0] rdata;
    logic       oe;
  } icc_regs_s;

  localparam icc_regs_s RESET_ST = '{
    wr_q:            1'b0,
    system_config:   REG_RESET,
    template_params: REG_RESET,
    irq_enable:      REG_RESET,
    rdata:           REG_RESET,
    byte_cnt:        2'h0,
    default:         1'b0
  };

  localparam int HBUS_W = 19;

  icc_regs_s   st;
  icc_regs_s   next_st;
  logic [18:0] hbus_raw;
  logic [18:0] hbus;
  logic        cs;
  logic        rd;
  logic        wr;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wr_take;

  // Pins cross into the clock domain; strobes idle high.
  // Address and data share the strobes' synchroniser, so they settle no later than the strobe does.
  assign hbus_raw = {host_cs_n, host_rd_n, host_wr_n, host_addr, host_data_in, 4'h0};

  icc_sync #(
    .W(HBUS_W)
  ) u_hbus_sync (
    .mclk       (mclk),
    .resetn     (resetn),
    .async_in   (hbus_raw),
    .sync_out   (hbus),
    .idle_value (19'h70000)
  );

  assign cs    = !hbus[18];
  assign rd    = !hbus[17];
  assign wr    = !hbus[16];
  assign addr  = hbus[15:12];
  assign wdata = hbus[11:4];

  // A write is taken once, at the settled leading edge of the write strobe.
  // Holding wr_q through the strobe stops a long strobe from writing twice.
  assign wr_take = cs && wr && !st.wr_q;

  function automatic logic is_mapped(input logic [3:0] a);
    is_mapped = (a == ADDR_SYS) || (a == ADDR_PARAM) || (a == ADDR_CMD) || (a == ADDR_IEN);
  endfunction

  always_comb begin
    logic irq_src;
    logic js_set;
    logic pause_set;
    irq_src    = 1'b0;
    js_set     = 1'b0;
    pause_set  = 1'b0;
    next_st    = st;
    next_st.wr_q     = cs && wr;
    next_st.start_p  = 1'b0;
    next_st.stop_p   = 1'b0;
    next_st.xfer_req = evt.code_xfer_request;

    // Hardware events; of the host writes below, only a soft reset clears these sticky bits.
    if (evt.marker_seen) begin
      next_st.marker_seen_flag = 1'b1;
    end
    // Overflow only flags the error; coding carries on and its output is known to be bad.
    if (evt.ff_overflow && evt.coding_active) begin
      next_st.ff_overflow_flag = 1'b1;
    end
    // Set terms are worked out first, so that a host clear in the same cycle never swallows them.
    js_set = evt.init_done
          || (!st.pause_select && evt.coding_active && evt.code_all_read)
          || (!st.pause_select && !evt.coding_active && evt.image_all_read);
    pause_set = st.process_cmd && evt.lines_done && st.pause_select;
    if (evt.init_done) begin
      next_st.ram_init_cmd = 1'b0;
    end
    if (js_set) begin
      next_st.completion_flag = 1'b1;
    end
    if (pause_set) begin
      next_st.pause_hit = 1'b1;
    end
    // Termination ends the run; a pause keeps it running so that the next start resumes.
    if (st.process_cmd && evt.lines_done && !st.pause_select) begin
      next_st.process_cmd = 1'b0;
    end
    if (evt.coding_active && evt.code_byte) begin
      next_st.byte_cnt = st.byte_cnt + 2'h1;
    end

    // Host writes; a clear from a write yields to a same-cycle hardware set.
    if (wr_take) begin
      unique case (addr)
        ADDR_SYS: begin
          next_st.system_config = wdata;
        end
        ADDR_PARAM: begin
          next_st.template_params = wdata;
        end
        ADDR_CMD: begin
          next_st.pause_select     = wdata[CMD_JP];
          next_st.context_xfer_cmd = wdata[CMD_RC];
          if (wdata[CMD_IC]) begin
            next_st.ram_init_cmd    = 1'b1;
            next_st.completion_flag = js_set;
          end
          if (wdata[CMD_JC]) begin
            next_st.process_cmd     = 1'b1;
            next_st.start_p         = 1'b1;
            next_st.pause_hit       = pause_set;
            next_st.byte_cnt        = 2'h0;
            next_st.completion_flag = js_set;
          end else if (st.process_cmd) begin
            next_st.process_cmd = 1'b0;
            next_st.stop_p      = 1'b1;
          end
        end
        ADDR_IEN: begin
          next_st.irq_enable = wdata & IEN_MASK;
        end
        default: begin
        end
      endcase
    end

    // Enabled sources drive the pin; pause raises it while the flag stays low.
    // The pin is registered, so it trails the status flag that raises it by one cycle.
    if (st.irq_enable[IEN_JE] && (st.completion_flag || st.pause_hit)) begin
      irq_src = 1'b1;
    end
    if (st.irq_enable[IEN_DE] && st.xfer_req) begin
      irq_src = 1'b1;
    end
    if (st.irq_enable[IEN_ME] && st.marker_seen_flag) begin
      irq_src = 1'b1;
    end
    if (st.irq_enable[IEN_SE] && st.ff_overflow_flag) begin
      irq_src = 1'b1;
    end
    next_st.irq = irq_src;

    // Read data is registered; command address returns status.
    next_st.oe    = cs && rd && is_mapped(addr);
    next_st.rdata = REG_RESET;
    if (cs && rd) begin
      unique case (addr)
        ADDR_SYS:   next_st.rdata = st.system_config;
        ADDR_PARAM: next_st.rdata = st.template_params;
        ADDR_CMD:   next_st.rdata = {2'h0, st.pause_select, st.ff_overflow_flag, st.irq,
                                     st.marker_seen_flag, st.xfer_req, st.completion_flag};
        ADDR_IEN:   next_st.rdata = st.irq_enable;
        default:    next_st.rdata = REG_RESET;
      endcase
    end

    // Soft reset holds everything else except wr_q and oe at its reset value while the bit is one.
    // Reads of the system register stay live so that software can see the reset bit.
    if (next_st.system_config[SYS_HR]) begin
      next_st = RESET_ST;
      next_st.system_config[SYS_HR] = 1'b1;
      next_st.wr_q  = cs && wr;
      next_st.oe    = cs && rd && is_mapped(addr);
      next_st.rdata = (cs && rd && addr == ADDR_SYS) ? st.system_config : REG_RESET;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  // Register fields fan out to the datapath configuration.
  always_comb begin
    cfg                    = '0;
    cfg.code_bus_width     = st.system_config[SYS_CB+1:SYS_CB];
    cfg.code_bit_order     = st.system_config[SYS_BS];
    cfg.code_byte_order    = st.system_config[SYS_BX];
    cfg.image_if_select    = st.system_config[SYS_PI];
    cfg.image_bus_width    = st.system_config[SYS_PB];
    cfg.image_bit_swap     = st.system_config[SYS_DS];
    cfg.adaptive_pixel_pos = {st.template_params[PAR_ATHI+1:PAR_ATHI], st.template_params[PAR_TM-1:PAR_ATLO]};
    cfg.template_select    = st.template_params[PAR_TM];
    cfg.pause_select       = st.pause_select;
    cfg.marker_pause       = st.irq_enable[IEN_MP];
  end

  // Zero pad bytes needed to close the final word of coded output.
  // A 16-bit bus needs one after an odd count; a 32-bit bus fills up to the next four.
  always_comb begin
    ctl                  = '0;
    ctl.core_reset       = st.system_config[SYS_HR];
    ctl.ram_init_run     = st.ram_init_cmd;
    ctl.process_run      = st.process_cmd;
    ctl.process_start    = st.start_p;
    ctl.process_stop     = st.stop_p;
    ctl.context_xfer_run = st.context_xfer_cmd;
    unique case (cfg.code_bus_width)
      CB_16:   ctl.pad_bytes = {1'b0, st.byte_cnt[0]};
      CB_32:   ctl.pad_bytes = 2'h0 - st.byte_cnt;
      default: ctl.pad_bytes = 2'h0;
    endcase
  end

  icc_bus_order u_order (
    .mclk      (mclk),
    .resetn    (resetn),
    .cfg       (cfg),
    .code_word (code_word),
    .pix_word  (pix_word),
    .code_bus  (code_bus),
    .image_bus (image_bus)
  );

  assign host_data_out     = st.rdata;
  assign host_data_oe      = st.oe;
  assign irq_out           = st.irq;
  assign code_xfer_request = st.xfer_req;

endmodule

// [icc_regs_checker.sv]
// Concurrent assertions on the ports of the image coder control register bank.
`timescale 1ns/100ps
module icc_regs_checker (
  // Clock and reset.
  input wire logic         mclk,
  input wire logic         resetn,
  // Datapath side.
  input icc_pkg::icc_evt_s evt,
  input wire logic [31:0]  code_word,
  input wire logic [31:0]  pix_word,
  input icc_pkg::icc_cfg_s cfg,
  input icc_pkg::icc_ctl_s ctl,
  input wire logic [31:0]  code_bus,
  input wire logic [31:0]  image_bus,
  // Interrupt and request pins.
  input wire logic         irq_out,
  input wire logic         code_xfer_request
);
  import icc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Soft reset leaves every command and the interrupt quiet.
  sequence s_quiet;
    !irq_out && !ctl.process_run && !ctl.ram_init_run && !ctl.context_xfer_run && cfg.code_bus_width == 2'h0;
  endsequence
  sequence s_lane0;
    code_bus[7] == $past(code_word[0]) && code_bus[0] == $past(code_word[7]);
  endsequence

  property p_xfer_req;
    code_xfer_request == $past(evt.code_xfer_request);
  endproperty
  property p_init_clear;
    evt.init_done |=> !ctl.ram_init_run;
  endproperty
  property p_term_clear;
    evt.lines_done && ctl.process_run && !cfg.pause_select |=> !ctl.process_run;
  endproperty
  property p_pause_hold;
    evt.lines_done && ctl.process_run && cfg.pause_select |=> ctl.process_run;
  endproperty
  property p_start;
    ctl.process_start |-> ##[0:1] ctl.process_run;
  endproperty
  property p_soft;
    ctl.core_reset |-> ##1 s_quiet;
  endproperty
  property p_code_lane;
    !cfg.code_bit_order && !cfg.code_byte_order && !ctl.core_reset |=> s_lane0;
  endproperty
  property p_image;
    cfg.image_if_select && !cfg.image_bus_width && !cfg.image_bit_swap && !ctl.core_reset
      |=> image_bus[31] == $past(pix_word[0]) && image_bus[0] == $past(pix_word[31]);
  endproperty
  property p_serial;
    !cfg.image_if_select && !ctl.core_reset |=> image_bus == 32'h0;
  endproperty
  property p_stop;
    ctl.process_stop |-> !ctl.process_run && $past(ctl.process_run);
  endproperty

  a_xfer_req: assert property (p_xfer_req) else $error("request pin differs from datapath request");
  a_init_clear: assert property (p_init_clear) else $error("init command did not clear");
  a_term_clear: assert property (p_term_clear) else $error("process command did not clear");
  a_pause_hold: assert property (p_pause_hold) else $error("process command cleared in pause mode");
  a_start: assert property (p_start) else $error("start pulse without process run");
  a_soft: assert property (p_soft) else $error("soft reset left state set");
  a_code_lane: assert property (p_code_lane) else $error("earliest code bit misplaced");
  a_image: assert property (p_image) else $error("image pixel order wrong");
  a_serial: assert property (p_serial) else $error("image bus driven in serial mode");
  a_stop: assert property (p_stop) else $error("stop pulse without a running process");
endmodule

// [icc_host_model.sv]
// Host processor model that runs strobed cycles on the register bus.
`timescale 1ns/100ps
module icc_host_model (
  // Clock.
  input wire logic        mclk,
  // Host bus pins.
  output logic            host_cs_n,
  output logic            host_rd_n,
  output logic            host_wr_n,
  output logic [3:0]      host_addr,
  output logic [7:0]      host_data_in,
  input wire logic [7:0]  host_data_out,
  input wire logic        host_data_oe
);
  initial begin
    host_cs_n = 1'b1;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    host_addr = 4'h0;
    host_data_in = 8'h00;
  end

  // Strobe and gap both last eight cycles, above the four the synchroniser needs.
  task automatic cycle(input logic [3:0] a, input logic [7:0] d, input logic rd, output logic [7:0] q,
                       output logic oe);
    @(posedge mclk);
    host_cs_n <= 1'b0;
    host_rd_n <= !rd;
    host_wr_n <= rd;
    host_addr <= a;
    host_data_in <= d;
    repeat (8) @(posedge mclk);
    q = host_data_out;
    oe = host_data_oe;
    host_cs_n <= 1'b1;
    host_rd_n <= 1'b1;
    host_wr_n <= 1'b1;
    // A released data bus must not keep showing the written value.
    host_data_in <= ~d;
    repeat (8) @(posedge mclk);
  endtask
endmodule

// [icc_regs_tb.sv]
// Self-checking testbench of the image coder control register bank.
`timescale 1ns/100ps
module icc_regs_tb;
  import icc_pkg::*;
  localparam logic [8:0] M_INIT  = 9'h100;
  localparam logic [8:0] M_LINES = 9'h080;
  localparam logic [8:0] M_CALL  = 9'h040;
  localparam logic [8:0] M_MARK  = 9'h010;
  localparam logic [8:0] M_OVF   = 9'h008;
  localparam logic [8:0] M_XREQ  = 9'h004;
  localparam logic [8:0] M_ACT   = 9'h002;
  localparam logic [8:0] M_BYTE  = 9'h001;
  logic        mclk;
  logic        resetn;
  logic        host_cs_n;
  logic        host_rd_n;
  logic        host_wr_n;
  logic [3:0]  host_addr;
  logic [7:0]  host_data_in;
  logic [7:0]  host_data_out;
  logic        host_data_oe;
  icc_evt_s    evt;
  logic [31:0] code_word;
  logic [31:0] pix_word;
  icc_cfg_s    cfg;
  icc_ctl_s    ctl;
  logic [31:0] code_bus;
  logic [31:0] image_bus;
  logic        irq_out;
  logic        code_xfer_request;
  int          fail_count;
  int          compares;
  int          m_done;
  int          m_ready;
  int          m_marker;
  int          m_ovf;
  int          m_pause;
  logic [7:0]  q;
  logic        oe;
  logic [7:0]  v;
  logic [6:0]  pos;

  icc_regs icc_regs_i (.mclk(mclk), .resetn(resetn), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
    .host_wr_n(host_wr_n), .host_addr(host_addr), .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .evt(evt), .code_word(code_word), .pix_word(pix_word), .cfg(cfg), .ctl(ctl),
    .code_bus(code_bus), .image_bus(image_bus), .irq_out(irq_out), .code_xfer_request(code_xfer_request));
  icc_host_model icc_host_model_i (.mclk(mclk), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
    .host_wr_n(host_wr_n), .host_addr(host_addr), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe));

  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic chk1(input string name, input logic seen, input logic exp);
    check(name, {31'h0, seen}, {31'h0, exp});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    icc_host_model_i.cycle(a, d, 1'b0, q, oe);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    icc_host_model_i.cycle(a, 8'h00, 1'b1, q, oe);
    check("read data", {24'h0, q}, {24'h0, exp});
    chk1("read oe", oe, 1'b1);
  endtask
  task automatic pulse(input logic [8:0] m);
    @(posedge mclk);
    evt <= evt | m;
    @(posedge mclk);
    evt <= evt & ~m;
    repeat (3) @(posedge mclk);
  endtask
  function automatic logic [7:0] stat(input int irq);
    return {2'b00, m_pause[0], m_ovf[0], irq[0], m_marker[0], m_ready[0], m_done[0]};
  endfunction
  function automatic logic [31:0] exp_code(input logic [31:0] w, input int wsel, input int lsb, input int swp);
    int n;
    n = (wsel == 2) ? 4 : (wsel == 1) ? 2 : 1;
    exp_code = 32'h0;
    for (int k = 0; k < n; k++) begin
      for (int j = 0; j < 8; j++) begin
        exp_code[8 * ((swp != 0) ? n - 1 - k : k) + j] = w[8 * k + ((lsb != 0) ? j : 7 - j)];
      end
    end
  endfunction
  function automatic logic [31:0] exp_img(input logic [31:0] w, input int par, input int narrow, input int rev);
    int n;
    n = (narrow != 0) ? 16 : 32;
    exp_img = 32'h0;
    for (int i = 0; i < n; i++) begin
      exp_img[(rev != 0) ? i : n - 1 - i] = (par != 0) ? w[i] : 1'b0;
    end
  endfunction

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // The whole sequence needs under 3000 cycles.
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    resetn = 1'b0;
    evt = '0;
    code_word = 32'h0;
    pix_word = 32'h0;
    fail_count = 0;
    compares = 0;
    {m_done, m_ready, m_marker, m_ovf, m_pause} = '0;
    void'($urandom(72640));
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    wr(4'h7, 8'hff);
    for (int a = 0; a < 4; a++) rd_chk(a[3:0], 8'h00);
    icc_host_model_i.cycle(4'h5, 8'h00, 1'b1, q, oe);
    chk1("unmapped oe", oe, 1'b0);
    // Every legal width with every swap, plus random parameters and enables.
    for (int wsel = 0; wsel < 3; wsel++) begin
      for (int s = 0; s < 4; s++) begin
        v = {s[1], (wsel != 0), s[1], s[0], s[0], wsel[1:0], 1'b0};
        wr(ADDR_SYS, v);
        rd_chk(ADDR_SYS, v);
        code_word <= $urandom;
        pix_word <= $urandom;
        repeat (3) @(posedge mclk);
        check("code bus", code_bus, exp_code(code_word, wsel, s[0], s[1]));
        check("image bus", image_bus, exp_img(pix_word, wsel != 0, s[1], s[0]));
        v = 8'($urandom);
        pos = {v[7:6], v[4:0]};
        if ((v[5] && pos inside {[1:4]}) || (!v[5] && pos inside {[1:2]})) v = v & 8'h20;
        wr(ADDR_PARAM, v);
        rd_chk(ADDR_PARAM, v);
        check("pixel pos", {25'h0, cfg.adaptive_pixel_pos}, {25'h0, v[7:6], v[4:0]});
        chk1("template", cfg.template_select, v[5]);
        v = 8'($urandom);
        wr(ADDR_IEN, v);
        rd_chk(ADDR_IEN, v & IEN_MASK);
      end
    end
    // Initialisation end raises the enabled done interrupt; masking it drops the pin.
    wr(ADDR_IEN, 8'h01);
    wr(ADDR_CMD, 8'h01);
    chk1("init run", ctl.ram_init_run, 1'b1);
    pulse(M_INIT);
    m_done = 1;
    chk1("init run", ctl.ram_init_run, 1'b0);
    chk1("irq", irq_out, 1'b1);
    rd_chk(ADDR_CMD, stat(1));
    rd_chk(ADDR_IEN, 8'h01);
    rd_chk(ADDR_CMD, stat(1));
    wr(ADDR_IEN, 8'h00);
    chk1("irq", irq_out, 1'b0);
    rd_chk(ADDR_CMD, stat(0));
    // Terminating coding on a 32-bit code bus with sticky error flags.
    wr(ADDR_SYS, 8'h04);
    wr(ADDR_CMD, 8'h02);
    m_done = 0;
    chk1("process run", ctl.process_run, 1'b1);
    @(posedge mclk);
    evt <= M_ACT | M_XREQ;
    m_ready = 1;
    repeat (5) pulse(M_BYTE);
    check("pad bytes", {30'h0, ctl.pad_bytes}, 32'h3);
    pulse(M_LINES);
    chk1("process run", ctl.process_run, 1'b0);
    pulse(M_OVF);
    pulse(M_MARK);
    pulse(M_CALL);
    m_ovf = 1;
    m_marker = 1;
    m_done = 1;
    chk1("xfer request", code_xfer_request, 1'b1);
    rd_chk(ADDR_CMD, stat(0));
    wr(ADDR_IEN, 8'h0c);
    chk1("irq", irq_out, 1'b1);
    rd_chk(ADDR_CMD, stat(1));
    wr(ADDR_IEN, 8'h02);
    chk1("irq", irq_out, 1'b1);
    wr(ADDR_IEN, 8'h00);
    // Pause after the lines, resume, then stop by hand.
    @(posedge mclk);
    evt <= M_ACT;
    m_ready = 0;
    wr(ADDR_CMD, 8'h0a);
    m_done = 0;
    m_pause = 1;
    wr(ADDR_IEN, 8'h01);
    chk1("irq", irq_out, 1'b0);
    pulse(M_LINES);
    chk1("process run", ctl.process_run, 1'b1);
    chk1("irq", irq_out, 1'b1);
    rd_chk(ADDR_CMD, stat(1));
    wr(ADDR_CMD, 8'h0a);
    chk1("irq", irq_out, 1'b0);
    wr(ADDR_CMD, 8'h08);
    chk1("process run", ctl.process_run, 1'b0);
    rd_chk(ADDR_CMD, stat(0));
    // Context transfer window, then soft reset.
    wr(ADDR_CMD, 8'h0c);
    chk1("context xfer", ctl.context_xfer_run, 1'b1);
    wr(ADDR_CMD, 8'h0a);
    chk1("context xfer", ctl.context_xfer_run, 1'b0);
    wr(ADDR_IEN, 8'h0c);
    chk1("irq", irq_out, 1'b1);
    wr(ADDR_SYS, 8'h01);
    chk1("core reset", ctl.core_reset, 1'b1);
    chk1("process run", ctl.process_run, 1'b0);
    chk1("irq", irq_out, 1'b0);
    wr(ADDR_SYS, 8'h00);
    for (int a = 0; a < 4; a++) rd_chk(a[3:0], 8'h00);
    tally_and_finish();
  end
endmodule

bind icc_regs icc_regs_checker icc_regs_checker_i (.mclk(mclk), .resetn(resetn), .evt(evt),
  .code_word(code_word), .pix_word(pix_word), .cfg(cfg), .ctl(ctl), .code_bus(code_bus),
  .image_bus(image_bus), .irq_out(irq_out), .code_xfer_request(code_xfer_request));
